// ### logic/pmc_pkg.sv
// pmc_pkg: constants and types of the power-mode controller
// assumes a 32-bit apb register bus and one clock domain
package pmc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_PCFG   = 8'h04;
    localparam logic [7:0] OFF_SCFG   = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_SUPPLY = 8'h10;
    // ctrl: [3:0] requested mode, [11:8] wake mode
    localparam int CTRL_REQ_LSB  = 0;
    localparam int CTRL_WAKE_LSB = 8;
    // pcfg: main cpu [1:0], math [3:2], legacy [5:4]
    localparam int PCFG_CPU_LSB  = 0;
    localparam int PCFG_MATH_LSB = 2;
    localparam int PCFG_LEG_LSB  = 4;
    // scfg: bit 0 gyro low-noise, bit 1 accel low-noise
    localparam int SCFG_GYRO_BIT  = 0;
    localparam int SCFG_ACCEL_BIT = 1;
    // status: [3:0] mode, bit 8 busy, bit 9 refused (write 1 clears)
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_REF_BIT  = 9;
    // power modes
    localparam logic [3:0] MODE_PDOWN  = 4'h0;
    localparam logic [3:0] MODE_DSLEEP = 4'h1;
    localparam logic [3:0] MODE_SLEEP  = 4'h2;
    localparam logic [3:0] MODE_SIX    = 4'h3;
    localparam logic [3:0] MODE_ACCEL  = 4'h4;
    localparam logic [3:0] MODE_GYRO   = 4'h5;
    localparam logic [3:0] MODE_CPU    = 4'h6;
    localparam logic [3:0] MODE_MATH   = 4'h7;
    localparam logic [3:0] MODE_LEGACY = 4'h8;
    // unit power codes; sensors use UNIT_ON as low-noise
    localparam logic [1:0] UNIT_OFF  = 2'h0;
    localparam logic [1:0] UNIT_DUTY = 2'h1;
    localparam logic [1:0] UNIT_ON   = 2'h2;
    // reset values
    localparam logic [3:0] RST_MODE  = MODE_SIX;
    localparam logic [3:0] RST_WAKE  = MODE_SIX;
    localparam logic [5:0] RST_PCFG  = 6'h15;
    localparam logic [1:0] RST_SCFG  = 2'h0;

    typedef enum logic [1:0] {SEQ_RUN, SEQ_SUSPEND, SEQ_APPLY} pmc_seq_type;

    typedef struct packed {
        logic [1:0] main_cpu;
        logic [1:0] math_coprocessor;
        logic [1:0] legacy_motion_coprocessor;
        logic [1:0] gyro;
        logic [1:0] accel;
        logic       logic_on;
        logic       retain;
        logic       rom_flash_on;
        logic       rc_osc_on;
        logic       por_wake_armed;
    } pmc_power_type;
endpackage : pmc_pkg

// ### logic/pmc_power_mode_controller.sv
// pmc_power_mode_controller: power-mode sequencer with apb registers
// assumes the host keeps apb protocol; active units ack suspend requests
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - power-down turns all digital off, only por stays armed for wake.
// - power-down drops retention; only flash contents survive.
// - deep sleep powers off rom, flash and rc oscillator, keeps logic retained.
// - sleep keeps digital logic powered and idle, rc oscillator off.
// - active modes may enter any sleep mode; never sleep to sleep.
// - six active modes: six-axis, accel, gyro, cpu, math, legacy.
// - in active modes units are off or duty-cycled unless the mode or the pcfg/scfg setting selects on.
// - all three sleep modes hold every processor and sensor off.
// - sensor modes take processor choices; gyro or accel off per mode.
// - single-processor modes run only that processor, everything else off.
// - sensors duty-cycled by default, low-noise only when selected.
// - host requests served in every mode after a clean suspend.
// - core supply chosen from the flash setting: external or regulators.
module pmc_power_mode_controller (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // wake, suspend handshake and flash supply setting
    input  wire logic                 ext_wake,
    input  wire logic                 suspend_ack,
    input  wire logic                 flash_ext_supply,
    output logic                      suspend_req,
    // power controls
    output pmc_pkg::pmc_power_type    power,
    output logic                      use_ext_supply
);
    function automatic logic is_sleep(input logic [3:0] m);
        return m <= pmc_pkg::MODE_SLEEP;
    endfunction : is_sleep

    function automatic logic is_valid(input logic [3:0] m);
        return m <= pmc_pkg::MODE_LEGACY;
    endfunction : is_valid

    function automatic logic [1:0] proc_code(input logic [1:0] c);
        // undefined choice falls back to off
        return (c == pmc_pkg::UNIT_DUTY || c == pmc_pkg::UNIT_ON) ? c : pmc_pkg::UNIT_OFF;
    endfunction : proc_code

    function automatic pmc_pkg::pmc_power_type power_of(input logic [3:0] m,
                                                       input logic [5:0] pc,
                                                       input logic [1:0] sc);
        pmc_pkg::pmc_power_type p;
        logic [1:0] g;
        logic [1:0] a;
        g = sc[pmc_pkg::SCFG_GYRO_BIT] ? pmc_pkg::UNIT_ON : pmc_pkg::UNIT_DUTY;
        a = sc[pmc_pkg::SCFG_ACCEL_BIT] ? pmc_pkg::UNIT_ON : pmc_pkg::UNIT_DUTY;
        // sleep modes start with every unit off
        p = '0;
        p.logic_on = 1'b1;
        p.retain = 1'b1;
        p.rom_flash_on = 1'b1;
        p.rc_osc_on = 1'b1;
        unique case (m)
            pmc_pkg::MODE_PDOWN: begin
                p.logic_on = 1'b0;
                p.retain = 1'b0;
                p.rom_flash_on = 1'b0;
                p.rc_osc_on = 1'b0;
                p.por_wake_armed = 1'b1;
            end
            pmc_pkg::MODE_DSLEEP: begin
                p.rom_flash_on = 1'b0;
                p.rc_osc_on = 1'b0;
                p.por_wake_armed = 1'b1;
            end
            pmc_pkg::MODE_SLEEP: begin
                p.rc_osc_on = 1'b0;
                p.por_wake_armed = 1'b1;
            end
            pmc_pkg::MODE_SIX, pmc_pkg::MODE_ACCEL, pmc_pkg::MODE_GYRO: begin
                p.main_cpu = proc_code(pc[pmc_pkg::PCFG_CPU_LSB +: 2]);
                p.math_coprocessor = proc_code(pc[pmc_pkg::PCFG_MATH_LSB +: 2]);
                p.legacy_motion_coprocessor = proc_code(pc[pmc_pkg::PCFG_LEG_LSB +: 2]);
                p.gyro = (m == pmc_pkg::MODE_ACCEL) ? pmc_pkg::UNIT_OFF : g;
                p.accel = (m == pmc_pkg::MODE_GYRO) ? pmc_pkg::UNIT_OFF : a;
            end
            pmc_pkg::MODE_CPU: p.main_cpu = pmc_pkg::UNIT_ON;
            pmc_pkg::MODE_MATH: p.math_coprocessor = pmc_pkg::UNIT_ON;
            pmc_pkg::MODE_LEGACY: p.legacy_motion_coprocessor = pmc_pkg::UNIT_ON;
            default: p.por_wake_armed = 1'b0;
        endcase
        return p;
    endfunction : power_of

    // control state
    pmc_pkg::pmc_seq_type seq;
    pmc_pkg::pmc_seq_type next_seq;
    logic [3:0]           mode;
    logic [3:0]           next_mode;
    logic [3:0]           target;
    logic [3:0]           next_target;
    logic [3:0]           wake_mode;
    logic [3:0]           next_wake_mode;
    logic [5:0]           pcfg;
    logic [5:0]           next_pcfg;
    logic [1:0]           scfg;
    logic [1:0]           next_scfg;
    logic                 refused;
    logic                 next_refused;
    logic                 supply_taken;
    logic                 next_supply_taken;
    logic                 next_use_ext_supply;
    logic                 next_suspend_req;
    pmc_pkg::pmc_power_type next_power;
    // bus state
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;

    logic       wr_fire;
    logic       rd_fire;
    logic       hit;
    logic [3:0] req;
    logic       req_ok;
    logic       wake_ok;

    // a write lands only at the edge where pready is seen high
    assign wr_fire = psel & penable & pready & pwrite;
    assign rd_fire = psel & penable & ~pready & ~pwrite;
    assign hit = paddr == pmc_pkg::OFF_CTRL || paddr == pmc_pkg::OFF_PCFG ||
                 paddr == pmc_pkg::OFF_SCFG || paddr == pmc_pkg::OFF_STATUS ||
                 paddr == pmc_pkg::OFF_SUPPLY;
    assign req = pwdata[pmc_pkg::CTRL_REQ_LSB +: 4];
    // from sleep only an active target is legal
    assign req_ok = is_valid(req) && !(is_sleep(mode) && is_sleep(req));
    assign wake_ok = ext_wake && is_sleep(mode) && is_valid(wake_mode) && !is_sleep(wake_mode);

    always_comb begin
        next_pready = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~hit;
        next_prdata = '0;
        if (rd_fire) begin
            unique case (paddr)
                pmc_pkg::OFF_CTRL: next_prdata = {20'h0, wake_mode, 4'h0, target};
                pmc_pkg::OFF_PCFG: next_prdata = {26'h0, pcfg};
                pmc_pkg::OFF_SCFG: next_prdata = {30'h0, scfg};
                pmc_pkg::OFF_STATUS: next_prdata = {22'h0, refused, seq != pmc_pkg::SEQ_RUN, 4'h0, mode};
                pmc_pkg::OFF_SUPPLY: next_prdata = {31'h0, use_ext_supply};
                default: next_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    always_comb begin
        next_seq = seq;
        next_mode = mode;
        next_target = target;
        next_wake_mode = wake_mode;
        next_pcfg = pcfg;
        next_scfg = scfg;
        next_refused = refused;
        next_suspend_req = 1'b0;
        next_power = power;
        next_supply_taken = 1'b1;
        // flash setting caught once after reset release
        next_use_ext_supply = supply_taken ? use_ext_supply : flash_ext_supply;
        if (wr_fire && paddr == pmc_pkg::OFF_STATUS && pwdata[pmc_pkg::STAT_REF_BIT]) begin
            next_refused = 1'b0;
        end
        if (wr_fire && paddr == pmc_pkg::OFF_PCFG) begin
            next_pcfg = pwdata[5:0];
        end
        if (wr_fire && paddr == pmc_pkg::OFF_SCFG) begin
            next_scfg = pwdata[1:0];
        end
        unique case (seq)
            pmc_pkg::SEQ_RUN: begin
                if (wr_fire && paddr == pmc_pkg::OFF_CTRL) begin
                    next_wake_mode = pwdata[pmc_pkg::CTRL_WAKE_LSB +: 4];
                    // refused requests leave the mode untouched
                    if (req_ok) begin
                        next_target = req;
                        next_seq = pmc_pkg::SEQ_SUSPEND;
                        next_suspend_req = 1'b1;
                    end else begin
                        next_refused = 1'b1;
                    end
                end else if (wake_ok) begin
                    next_target = wake_mode;
                    next_seq = pmc_pkg::SEQ_SUSPEND;
                    next_suspend_req = 1'b1;
                end
            end
            // hold until activity has stopped cleanly
            pmc_pkg::SEQ_SUSPEND: begin
                next_suspend_req = ~suspend_ack;
                if (suspend_ack) begin
                    next_seq = pmc_pkg::SEQ_APPLY;
                end
            end
            pmc_pkg::SEQ_APPLY: begin
                // the new mode drives every unit
                next_mode = target;
                next_power = power_of(target, pcfg, scfg);
                next_seq = pmc_pkg::SEQ_RUN;
            end
            default: next_seq = pmc_pkg::SEQ_RUN;
        endcase
        // busy ctrl writes are dropped and flagged; set beats clear
        if (seq != pmc_pkg::SEQ_RUN && wr_fire && paddr == pmc_pkg::OFF_CTRL) begin
            next_refused = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            seq <= pmc_pkg::SEQ_RUN;
            mode <= pmc_pkg::RST_MODE;
            target <= pmc_pkg::RST_MODE;
            wake_mode <= pmc_pkg::RST_WAKE;
            pcfg <= pmc_pkg::RST_PCFG;
            scfg <= pmc_pkg::RST_SCFG;
            refused <= 1'b0;
            supply_taken <= 1'b0;
            use_ext_supply <= 1'b0;
            suspend_req <= 1'b0;
            power <= power_of(pmc_pkg::RST_MODE, pmc_pkg::RST_PCFG, pmc_pkg::RST_SCFG);
        end else begin
            seq <= next_seq;
            mode <= next_mode;
            target <= next_target;
            wake_mode <= next_wake_mode;
            pcfg <= next_pcfg;
            scfg <= next_scfg;
            refused <= next_refused;
            supply_taken <= next_supply_taken;
            use_ext_supply <= next_use_ext_supply;
            suspend_req <= next_suspend_req;
            power <= next_power;
        end
    end
endmodule : pmc_power_mode_controller

`default_nettype wire

// ### testbench/pmc_pm_asserts.sv
// pmc_pm_asserts: port-level checks of the power-mode controller
// assumes it is bound to the controller top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module pmc_pm_asserts (
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  reset_n,
    // apb
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // wake, suspend and supply
    input wire logic                  ext_wake,
    input wire logic                  suspend_ack,
    input wire logic                  flash_ext_supply,
    input wire logic                  suspend_req,
    input wire pmc_pkg::pmc_power_type power,
    input wire logic                  use_ext_supply
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_apb_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
        else $error("apb answer not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_sleep_units: assert property (!power.rc_osc_on |-> power[14:5] == 10'h000)
        else $error("unit powered in a sleep mode");
    a_pdown_state: assert property (!power.logic_on |-> !power.retain && !power.rom_flash_on && power.por_wake_armed)
        else $error("power-down state wrong");
    a_dsleep_state: assert property (power.logic_on && !power.rom_flash_on |-> power.retain && !power.rc_osc_on)
        else $error("deep sleep state wrong");
    a_unit_codes: assert property (power.gyro != 2'h3 && power.accel != 2'h3 && power.main_cpu != 2'h3)
        else $error("illegal unit code");
    a_change_suspended: assert property (!$stable(power) |-> $past(suspend_req, 2))
        else $error("power changed without suspend");
    a_req_release: assert property (suspend_req && suspend_ack |=> !suspend_req)
        else $error("suspend request not released");
    // the capture lands at the release edge, so hold is only checked from two edges on
    a_supply_hold: assert property ($past(reset_n, 2) |-> $stable(use_ext_supply))
        else $error("supply select changed");
    a_no_sleep_hop: assert property ($past(!power.rc_osc_on) && !power.rc_osc_on |-> $stable(power))
        else $error("sleep to sleep move");

    c_pdown: cover property (!power.logic_on);
    c_slverr: cover property (pslverr);
    c_suspend: cover property (suspend_req && suspend_ack);
endmodule : pmc_pm_asserts
`default_nettype wire

// ### testbench/pmc_unit_model.sv
// pmc_unit_model: active units that acknowledge a suspend request
// assumes ack_delay is steady while a request is open
`timescale 1ns/1ps
`default_nettype none
module pmc_unit_model (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       reset_n,
    // handshake
    input wire logic       suspend_req,
    input wire logic [3:0] ack_delay,
    output logic           suspend_ack
);
    logic [3:0] wait_cnt;
    always_ff @(posedge ref_clk) begin
        if (!reset_n || !suspend_req) begin
            wait_cnt    <= 4'h0;
            suspend_ack <= 1'b0;
        end else if (wait_cnt >= ack_delay) begin
            suspend_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : pmc_unit_model
`default_nettype wire

// ### testbench/testbench.sv
// testbench: apb-driven check of the power-mode controller
// assumes the unit model answers suspend requests
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                   ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, rerr;
    logic                   ext_wake, suspend_ack, flash_ext_supply, suspend_req, use_ext_supply;
    logic [7:0]             paddr;
    logic [31:0]            pwdata, prdata, rdat;
    logic [3:0]             ack_delay, md;
    logic [5:0]             pcfg;
    logic [1:0]             scfg;
    pmc_pkg::pmc_power_type power;
    int                     bad_count, checked, cycles;

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    pmc_power_mode_controller uut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_wake(ext_wake), .suspend_ack(suspend_ack), .flash_ext_supply(flash_ext_supply),
        .suspend_req(suspend_req), .power(power), .use_ext_supply(use_ext_supply));
    pmc_unit_model u_units (.ref_clk(ref_clk), .reset_n(reset_n), .suspend_req(suspend_req),
        .ack_delay(ack_delay), .suspend_ack(suspend_ack));

    task automatic end_sim;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // answer read at the rising edge where pready is seen, before that edge's updates land
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            end_sim();
        end
    endtask : apb

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            apb(1'b0, pmc_pkg::OFF_STATUS, 32'h0);
            n++;
        end while (rdat[pmc_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 40);
        if (n >= 40) begin
            bad_count++;
            end_sim();
        end
    endtask : wait_idle

    function automatic logic [1:0] pcode(input logic [1:0] c);
        return (c == 2'h3) ? pmc_pkg::UNIT_OFF : c;
    endfunction : pcode

    function automatic pmc_pkg::pmc_power_type exp_pw(input logic [3:0] m);
        pmc_pkg::pmc_power_type p;
        p = '0;
        {p.logic_on, p.retain, p.rom_flash_on, p.rc_osc_on} = 4'hf;
        case (m)
            pmc_pkg::MODE_PDOWN:  {p.logic_on, p.retain, p.rom_flash_on, p.rc_osc_on, p.por_wake_armed} = 5'h01;
            pmc_pkg::MODE_DSLEEP: {p.rom_flash_on, p.rc_osc_on} = 2'h0;
            pmc_pkg::MODE_SLEEP:  p.rc_osc_on = 1'b0;
            pmc_pkg::MODE_CPU:    p.main_cpu = pmc_pkg::UNIT_ON;
            pmc_pkg::MODE_MATH:   p.math_coprocessor = pmc_pkg::UNIT_ON;
            pmc_pkg::MODE_LEGACY: p.legacy_motion_coprocessor = pmc_pkg::UNIT_ON;
            default: begin
                p.main_cpu = pcode(pcfg[1:0]);
                p.math_coprocessor = pcode(pcfg[3:2]);
                p.legacy_motion_coprocessor = pcode(pcfg[5:4]);
                if (m != pmc_pkg::MODE_ACCEL) p.gyro = scfg[0] ? pmc_pkg::UNIT_ON : pmc_pkg::UNIT_DUTY;
                if (m != pmc_pkg::MODE_GYRO) p.accel = scfg[1] ? pmc_pkg::UNIT_ON : pmc_pkg::UNIT_DUTY;
            end
        endcase
        return p;
    endfunction : exp_pw

    // wake arming is only pinned down in power-down
    task automatic expect_mode(input logic [3:0] m);
        logic [14:0] mk;
        mk = (m == pmc_pkg::MODE_PDOWN) ? 15'h7fff : 15'h7ffe;
        wait_idle();
        chk("mode", {28'h0, m}, {28'h0, rdat[3:0]});
        chk("power", {17'h0, exp_pw(m) & mk}, {17'h0, power & mk});
    endtask : expect_mode

    task automatic set_mode(input logic [3:0] m);
        apb(1'b1, pmc_pkg::OFF_CTRL, {20'h0, pmc_pkg::MODE_GYRO, 4'h0, m});
        wait_idle();
    endtask : set_mode

    task automatic check_refused;
        chk("refused", 32'h1, {31'h0, rdat[pmc_pkg::STAT_REF_BIT]});
        apb(1'b1, pmc_pkg::OFF_STATUS, 32'h200);
    endtask : check_refused

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 20000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        {psel, penable, pwrite, ext_wake, paddr, pwdata} = '0;
        {reset_n, bad_count, checked, cycles} = '0;
        flash_ext_supply = 1'b1;
        ack_delay = 4'h0;
        pcfg = pmc_pkg::RST_PCFG;
        scfg = pmc_pkg::RST_SCFG;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        expect_mode(pmc_pkg::MODE_SIX);
        apb(1'b0, pmc_pkg::OFF_CTRL, 32'h0);
        chk("ctrl", {20'h0, pmc_pkg::RST_WAKE, 4'h0, pmc_pkg::RST_MODE}, rdat);
        apb(1'b0, pmc_pkg::OFF_PCFG, 32'h0);
        chk("pcfg", {26'h0, pmc_pkg::RST_PCFG}, rdat);
        flash_ext_supply <= 1'b0;
        apb(1'b0, pmc_pkg::OFF_SUPPLY, 32'h0);
        chk("supply", 32'h1, rdat);
        chk("use_ext", 32'h1, {31'h0, use_ext_supply});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", 32'h1, {31'h0, rerr});
        pcfg = 6'h36;
        scfg = 2'h1;
        apb(1'b1, pmc_pkg::OFF_PCFG, {26'h0, pcfg});
        apb(1'b1, pmc_pkg::OFF_SCFG, {30'h0, scfg});
        for (int i = 4; i <= 9; i++) begin
            md = (i == 9) ? pmc_pkg::MODE_SIX : i[3:0];
            ack_delay <= i[0] ? 4'h6 : 4'h0;
            set_mode(md);
            expect_mode(md);
        end
        apb(1'b1, pmc_pkg::OFF_CTRL, 32'h9);
        expect_mode(pmc_pkg::MODE_SIX);
        check_refused();
        for (int s = 0; s <= 2; s++) begin
            set_mode(s[3:0]);
            expect_mode(s[3:0]);
            set_mode((s == 2) ? pmc_pkg::MODE_DSLEEP : pmc_pkg::MODE_SLEEP);
            expect_mode(s[3:0]);
            check_refused();
            ext_wake <= 1'b1;
            @(posedge ref_clk);
            ext_wake <= 1'b0;
            expect_mode(pmc_pkg::MODE_GYRO);
        end
        ack_delay <= 4'h8;
        apb(1'b1, pmc_pkg::OFF_CTRL, {28'h0, pmc_pkg::MODE_CPU});
        apb(1'b1, pmc_pkg::OFF_CTRL, {28'h0, pmc_pkg::MODE_MATH});
        expect_mode(pmc_pkg::MODE_CPU);
        check_refused();
        end_sim();
    end
endmodule : testbench

bind pmc_power_mode_controller pmc_pm_asserts u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_wake(ext_wake), .suspend_ack(suspend_ack), .flash_ext_supply(flash_ext_supply),
    .suspend_req(suspend_req), .power(power), .use_ext_supply(use_ext_supply));
`default_nettype wire
